// ### shared/msic_pkg.sv
// Constants for the message-signalled interrupt capability block.
// Assumes a 32-bit configuration access port supplied by the bus target logic.
package msic_pkg;
  localparam logic [7:0]  CAP_BASE_OFFSET   = 8'hF0;
  localparam logic [7:0]  ADDR_LOW_OFFSET   = 8'hF4;
  localparam logic [7:0]  ADDR_HIGH_OFFSET  = 8'hF8;
  localparam logic [7:0]  PAYLOAD_OFFSET    = 8'hFC;
  localparam logic [7:0]  CAP_ID_VALUE      = 8'h05;
  localparam logic [7:0]  NEXT_PTR_VALUE    = 8'h00;
  localparam logic [2:0]  MULTI_CAP_VALUE   = 3'h0;
  localparam logic        WIDE_ADDR_VALUE   = 1'b1;
  localparam int          CTRL_ENABLE_BIT   = 0;
  localparam int          CTRL_MCAP_LSB     = 1;
  localparam int          CTRL_MEN_LSB      = 4;
  localparam int          CTRL_WIDE_BIT     = 7;
  localparam int          CTRL_FIELD_LSB    = 16;
  localparam logic [2:0]  MULTI_EN_RESET    = 3'h0;
  localparam logic [31:0] ADDR_RESET        = 32'h0000_0000;
  localparam logic [15:0] PAYLOAD_RESET     = 16'h0000;
  localparam int          CAUSE_WIDTH       = 32;
endpackage : msic_pkg

// ### shared/msic_cfg_if.sv
// Carries configuration state from the register file to the delivery engine.
// Assumes both ends share one clock.
interface msic_cfg_if;
  logic        msg_enable;
  logic [63:0] msg_address;
  logic [15:0] msg_payload;
  modport regs (output msg_enable, output msg_address, output msg_payload);
  modport engine (input msg_enable, input msg_address, input msg_payload);
endinterface : msic_cfg_if

// ### src/msic_regs.sv
// Capability register set: control, 64-bit address, payload.
// Assumes one-cycle write and read strobes from the configuration target.
module msic_regs
  import msic_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  // Configuration access
  input  wire logic        wr_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  be_in,
  input  wire logic        visible_in,
  output logic [31:0]      rdata_comb_out,
  // Configuration state
  msic_cfg_if.regs         cfg
);
  import msic_pkg::*;

  logic        enable_reg, enable_next;
  logic [2:0]  multi_en_reg, multi_en_next;
  logic [31:0] addr_low_reg, addr_low_next;
  logic [31:0] addr_high_reg, addr_high_next;
  logic [15:0] payload_reg, payload_next;
  logic [15:0] ctrl;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb
  begin
    logic [31:0] t;
    t              = 32'h0000_0000;
    enable_next    = enable_reg;
    multi_en_next  = multi_en_reg;
    addr_low_next  = addr_low_reg;
    addr_high_next = addr_high_reg;
    payload_next   = payload_reg;
    if (wr_in && visible_in)
    begin
      unique case (addr_in)
        CAP_BASE_OFFSET:
        begin
          if (be_in[2])
          begin
            enable_next   = wdata_in[CTRL_FIELD_LSB + CTRL_ENABLE_BIT];
            multi_en_next = wdata_in[CTRL_FIELD_LSB + CTRL_MEN_LSB +: 3];
          end
        end
        ADDR_LOW_OFFSET:
        begin
          t             = merge(addr_low_reg, wdata_in, be_in);
          addr_low_next = {t[31:2], 2'h0};
        end
        ADDR_HIGH_OFFSET: addr_high_next = merge(addr_high_reg, wdata_in, be_in);
        PAYLOAD_OFFSET:
        begin
          t            = merge({16'h0000, payload_reg}, wdata_in, be_in);
          payload_next = t[15:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      enable_reg    <= 1'b0;
      multi_en_reg  <= MULTI_EN_RESET;
      addr_low_reg  <= ADDR_RESET;
      addr_high_reg <= ADDR_RESET;
      payload_reg   <= PAYLOAD_RESET;
    end
    else
    begin
      enable_reg    <= enable_next;
      multi_en_reg  <= multi_en_next;
      addr_low_reg  <= addr_low_next;
      addr_high_reg <= addr_high_next;
      payload_reg   <= payload_next;
    end
  end

  // Reserved high byte reads zero, single-message code and wide address are fixed.
  assign ctrl = {8'h00, WIDE_ADDR_VALUE, multi_en_reg, MULTI_CAP_VALUE, enable_reg};

  always_comb
  begin
    rdata_comb_out = 32'h0000_0000;
    if (visible_in)
    begin
      unique case (addr_in)
        CAP_BASE_OFFSET:  rdata_comb_out = {ctrl, NEXT_PTR_VALUE, CAP_ID_VALUE};
        ADDR_LOW_OFFSET:  rdata_comb_out = addr_low_reg;
        ADDR_HIGH_OFFSET: rdata_comb_out = addr_high_reg;
        PAYLOAD_OFFSET:   rdata_comb_out = {16'h0000, payload_reg};
        default:          rdata_comb_out = 32'h0000_0000;
      endcase
    end
  end

  assign cfg.msg_enable  = enable_reg & visible_in;
  assign cfg.msg_address = {addr_high_reg, addr_low_reg};
  assign cfg.msg_payload = payload_reg;
endmodule : msic_regs

// ### src/msic_engine.sv
// Decides when to raise the pin or issue one message write.
// Assumes the bus master holds done high one cycle when the write completes.
module msic_engine
  import msic_pkg::*;
#(
  parameter int CW = CAUSE_WIDTH
)
(
  // Clock and reset
  input  wire logic          mclk_in,
  input  wire logic          reset_in,
  // Interrupt causes and message completion
  input  wire logic [CW-1:0] cause_in,
  input  wire logic [CW-1:0] mask_in,
  input  wire logic          cause_read_in,
  input  wire logic          done_in,
  // Results
  output logic               req_out,
  output logic               pin_out,
  // Configuration state
  msic_cfg_if.engine         cfg
);
  import msic_pkg::*;

  typedef enum {ST_IDLE, ST_SEND, ST_WAIT_READ} msic_state_e;
  msic_state_e state_reg, state_next;
  logic        pending, prev_pending_reg;
  logic        req_reg, req_next, pin_reg, pin_next;

  assign pending = |(cause_in & mask_in);

  always_comb
  begin
    state_next = state_reg;
    req_next   = 1'b0;
    pin_next   = ~cfg.msg_enable & pending;
    unique case (state_reg)
      ST_IDLE:
      begin
        // A new rising event is required; a cause left set re-fires only after a cause read clears the history.
        if (cfg.msg_enable && pending && !prev_pending_reg)
        begin
          state_next = ST_SEND;
          req_next   = 1'b1;
        end
      end
      ST_SEND:
      begin
        req_next = ~done_in;
        if (done_in)
        begin
          state_next = ST_WAIT_READ;
        end
      end
      ST_WAIT_READ:
      begin
        if (cause_read_in)
        begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      state_reg        <= ST_IDLE;
      req_reg          <= 1'b0;
      pin_reg          <= 1'b0;
      prev_pending_reg <= 1'b0;
    end
    else
    begin
      state_reg        <= state_next;
      req_reg          <= req_next;
      pin_reg          <= pin_next;
      // A read clears the history, so a cause arriving afterwards counts as new.
      prev_pending_reg <= cause_read_in ? 1'b0 : pending;
    end
  end

  assign req_out = req_reg;
  assign pin_out = pin_reg;
endmodule : msic_engine

// ### src/msic_top.sv
// Top: configuration port, cause inputs, message request and pin outputs.
// Assumes a bus master that performs the write and pulses msg_done_in.
module msic_top
  import msic_pkg::*;
#(
  parameter int CW = msic_pkg::CAUSE_WIDTH
)
(
  // Clock and reset
  input  wire logic          mclk_in,
  input  wire logic          reset_in,
  // Configuration access
  input  wire logic          cfg_wr_in,
  input  wire logic          cfg_rd_in,
  input  wire logic [7:0]    cfg_addr_in,
  input  wire logic [31:0]   cfg_wdata_in,
  input  wire logic [3:0]    cfg_be_in,
  output logic [31:0]        cfg_rdata_out,
  output logic               cfg_rvalid_out,
  // Straps
  input  wire logic          conventional_mode_in,
  input  wire logic          nv_msi_disable_in,
  // Interrupt causes
  input  wire logic [CW-1:0] interrupt_cause_register_in,
  input  wire logic [CW-1:0] interrupt_mask_in,
  input  wire logic          cause_read_in,
  // Message write
  output logic               msg_req_out,
  output logic [63:0]        msg_addr_out,
  output logic [31:0]        msg_data_out,
  input  wire logic          msg_done_in,
  // Legacy pin
  output logic               int_pin_n_out
);
  import msic_pkg::*;

  msic_cfg_if cfg ();
  logic        visible_reg, visible_next;
  logic [31:0] rdata_comb, rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  logic [63:0] addr_reg, addr_next;
  logic [31:0] data_reg, data_next;
  logic        req_w, pin_w;

  msic_regs u_regs (
    .mclk_in        (mclk_in),
    .reset_in       (reset_in),
    .wr_in          (cfg_wr_in),
    .addr_in        (cfg_addr_in),
    .wdata_in       (cfg_wdata_in),
    .be_in          (cfg_be_in),
    .visible_in     (visible_reg),
    .rdata_comb_out (rdata_comb),
    .cfg            (cfg.regs)
  );

  msic_engine #(.CW(CW)) u_engine (
    .mclk_in       (mclk_in),
    .reset_in      (reset_in),
    .cause_in      (interrupt_cause_register_in),
    .mask_in       (interrupt_mask_in),
    .cause_read_in (cause_read_in),
    .done_in       (msg_done_in),
    .req_out       (req_w),
    .pin_out       (pin_w),
    .cfg           (cfg.engine)
  );

  // Straps come from logic in this clock domain, so no synchroniser is needed.
  always_comb
  begin
    visible_next = ~(conventional_mode_in & nv_msi_disable_in);
    rdata_next   = cfg_rd_in ? rdata_comb : rdata_reg;
    rvalid_next  = cfg_rd_in;
    // Freeze target while a message is in flight so it cannot tear mid-write.
    addr_next    = req_w ? addr_reg : cfg.msg_address;
    data_next    = req_w ? data_reg : {16'h0000, cfg.msg_payload};
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      visible_reg <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
      rvalid_reg  <= 1'b0;
      addr_reg    <= 64'h0000_0000_0000_0000;
      data_reg    <= 32'h0000_0000;
    end
    else
    begin
      visible_reg <= visible_next;
      rdata_reg   <= rdata_next;
      rvalid_reg  <= rvalid_next;
      addr_reg    <= addr_next;
      data_reg    <= data_next;
    end
  end

  assign cfg_rdata_out  = rdata_reg;
  assign cfg_rvalid_out = rvalid_reg;
  assign msg_req_out    = req_w;
  assign msg_addr_out   = addr_reg;
  assign msg_data_out   = data_reg;
  assign int_pin_n_out  = ~pin_w;
endmodule : msic_top

// ### verif/msic_sva.sv
// Checker for the message interrupt block, seeing only top-level ports.
// Assumes one clock and a synchronous active-high reset.
module msic_sva
(
  // Watched ports
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic        cfg_rd_in,
  input wire logic        cfg_rvalid_out,
  input wire logic        cause_read_in,
  input wire logic        msg_req_out,
  input wire logic [63:0] msg_addr_out,
  input wire logic [31:0] msg_data_out,
  input wire logic        msg_done_in,
  input wire logic        int_pin_n_out
);
  // Set once a message completes; only a cause read may re-arm delivery.
  logic blk_reg;
  logic blk_next;
  always_comb blk_next = cause_read_in ? 1'b0 : (blk_reg | (msg_req_out & msg_done_in));
  always_ff @(posedge mclk_in) blk_reg <= reset_in ? 1'b0 : blk_next;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  pin_quiet_a:
    assert property ($rose(msg_req_out) |-> int_pin_n_out) else $error("pin low at message");
  req_hold_a:
    assert property (msg_req_out && !msg_done_in |=> msg_req_out) else $error("request lost");
  req_drop_a:
    assert property (msg_req_out && msg_done_in |=> !msg_req_out) else $error("request stuck");
  data_top_a:
    assert property (msg_req_out |-> msg_data_out[31:16] == 16'h0000) else $error("data high");
  addr_hold_a:
    assert property (msg_req_out ##1 msg_req_out |-> $stable(msg_addr_out) && $stable(msg_data_out))
      else $error("message moved");
  rd_answer_a:
    assert property (cfg_rd_in |=> cfg_rvalid_out) else $error("no read answer");
  rv_cause_a:
    assert property (cfg_rvalid_out |-> $past(cfg_rd_in)) else $error("stray read answer");
  no_repeat_a:
    assert property ($rose(msg_req_out) |-> !blk_reg) else $error("message without cause read");
  cover property ($rose(msg_req_out));
  cover property (blk_reg && cause_read_in);
  cover property (cfg_rvalid_out);
endmodule : msic_sva
bind msic_top msic_sva chk_u (.mclk_in, .reset_in, .cfg_rd_in, .cfg_rvalid_out, .cause_read_in,
  .msg_req_out, .msg_addr_out, .msg_data_out, .msg_done_in, .int_pin_n_out);

// ### verif/msic_host.sv
// Host bus model: completes each message write after a set wait.
// Assumes the block holds its request until the completion pulse.
module msic_host
(
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic [3:0]  wait_in,
  input  wire logic        req_in,
  input  wire logic [63:0] addr_in,
  input  wire logic [31:0] data_in,
  output logic             done_out,
  output logic [7:0]       count_out,
  output logic [95:0]      last_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  always @(posedge mclk_in)
  begin
    done_out <= 1'b0;
    if (reset_in)
    begin
      cnt <= 4'h0;
      count_out <= 8'h00;
    end
    else if (req_in && !done_out)
    begin
      cnt <= cnt + 4'h1;
      if (cnt == wait_in)
      begin
        done_out <= 1'b1;
        cnt <= 4'h0;
        count_out <= count_out + 8'h01;
        last_out <= {addr_in, data_in};
      end
    end
  end
endmodule : msic_host

// ### verif/testbench.sv
// Self-checking bench for the message interrupt block.
// Assumes the host model answers every message write.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk;
  logic        rst;
  logic        wr;
  logic        rd;
  logic        conv;
  logic        nvd;
  logic        crd;
  logic        done;
  logic        rv;
  logic        req;
  logic        pin_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] cause;
  logic [31:0] mask;
  logic [31:0] mdata;
  logic [63:0] maddr;
  logic [3:0]  be;
  logic [3:0]  hw;
  logic [7:0]  cnt;
  logic [95:0] last;
  int          n_errors = 0;
  int          total_checks = 0;
  msic_top #(.CW(32)) dut_u (.mclk_in(mclk), .reset_in(rst), .cfg_wr_in(wr), .cfg_rd_in(rd),
    .cfg_addr_in(addr), .cfg_wdata_in(wdata), .cfg_be_in(be), .cfg_rdata_out(rdata),
    .cfg_rvalid_out(rv), .conventional_mode_in(conv), .nv_msi_disable_in(nvd),
    .interrupt_cause_register_in(cause), .interrupt_mask_in(mask), .cause_read_in(crd),
    .msg_req_out(req), .msg_addr_out(maddr), .msg_data_out(mdata), .msg_done_in(done),
    .int_pin_n_out(pin_n));
  msic_host host_u (.mclk_in(mclk), .reset_in(rst), .wait_in(hw), .req_in(req),
    .addr_in(maddr), .data_in(mdata), .done_out(done), .count_out(cnt), .last_out(last));
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic cw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    be <= b;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : cw
  task automatic cr(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(nm, {rv, rdata}, {1'b1, e});
  endtask : cr
  task automatic wait_req(input logic v);
    for (int i = 0; i < 40 && req !== v; i++)
      @(negedge mclk);
    chk("req_wait", req, v);
  endtask : wait_req
  task automatic set_cause(input logic [31:0] c, input logic [31:0] m);
    @(posedge mclk);
    cause <= c;
    mask <= m;
    repeat (3) @(negedge mclk);
  endtask : set_cause
  task automatic t_reset;
    cr(8'hF0, 32'h0080_0005, "ctrl_id");
    cr(8'hF4, 32'h0000_0000, "addr_lo");
    cr(8'hF8, 32'h0000_0000, "addr_hi");
    cr(8'hFC, 32'h0000_0000, "payload");
    $display("t_reset finished");
  endtask : t_reset
  task automatic t_pin;
    set_cause(32'h0000_0004, 32'h0000_0000);
    chk("pin_masked", pin_n, 1'b1);
    set_cause(32'h0000_0004, 32'hFFFF_FFFF);
    chk("pin_set", pin_n, 1'b0);
    set_cause(32'h0000_0000, 32'hFFFF_FFFF);
    chk("pin_clear", pin_n, 1'b1);
    chk("no_msg", cnt, 8'h00);
    $display("t_pin finished");
  endtask : t_pin
  task automatic t_regs;
    cw(8'hF0, 32'hFFFF_FFFF, 4'h3);
    cw(8'hF4, 32'h1234_5678, 4'hF);
    cw(8'hF8, 32'hA5A5_0001, 4'hF);
    cw(8'hFC, 32'hFFFF_BEEF, 4'hF);
    cw(8'hE0, 32'hFFFF_FFFF, 4'hF);
    cw(8'hF0, 32'hFF0F_0000, 4'hC);
    cr(8'hF0, 32'h0081_0005, "ctrl_en");
    cr(8'hF4, 32'h1234_5678, "addr_lo");
    cr(8'hF8, 32'hA5A5_0001, "addr_hi");
    cr(8'hFC, 32'h0000_BEEF, "payload");
    cr(8'hE0, 32'h0000_0000, "unmapped");
    $display("t_regs finished");
  endtask : t_regs
  task automatic t_msg;
    @(posedge mclk);
    cause <= 32'h0000_0001;
    wait_req(1'b1);
    chk("msg_addr", maddr, 64'hA5A5_0001_1234_5678);
    chk("msg_data", mdata, 32'h0000_BEEF);
    chk("pin_off", pin_n, 1'b1);
    wait_req(1'b0);
    chk("host_rec", last, {64'hA5A5_0001_1234_5678, 32'h0000_BEEF});
    hw <= 4'h0;
    set_cause(32'h0000_0000, 32'hFFFF_FFFF);
    set_cause(32'h0000_0002, 32'hFFFF_FFFF);
    repeat (6) @(negedge mclk);
    chk("no_repeat", cnt, 8'h01);
    @(posedge mclk);
    crd <= 1'b1;
    @(posedge mclk);
    crd <= 1'b0;
    wait_req(1'b1);
    wait_req(1'b0);
    chk("second", cnt, 8'h02);
    @(posedge mclk);
    cause <= 32'h0000_0000;
    $display("t_msg finished");
  endtask : t_msg
  task automatic t_hide;
    @(posedge mclk);
    conv <= 1'b1;
    nvd <= 1'b1;
    cr(8'hF0, 32'h0000_0000, "hidden");
    cw(8'hFC, 32'h0000_1111, 4'hF);
    @(posedge mclk);
    conv <= 1'b0;
    nvd <= 1'b0;
    cr(8'hF0, 32'h0081_0005, "shown");
    cr(8'hFC, 32'h0000_BEEF, "hide_wr");
    $display("t_hide finished");
  endtask : t_hide
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Full run is under two hundred cycles; the 4000-cycle limit leaves wide margin.
  initial
  begin
    #200000;
    n_errors++;
    summarize();
  end
  initial
  begin
    {wr, rd, conv, nvd, crd} = 5'h00;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    be = 4'h0;
    cause = 32'h0000_0000;
    mask = 32'h0000_0000;
    hw = 4'h3;
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_pin();
    t_regs();
    t_msg();
    t_hide();
    summarize();
  end
endmodule : testbench
